// ### verilog/jcp_defines.svh
// Constants of the test-port configuration loader
`ifndef JCP_DEFINES_SVH
`define JCP_DEFINES_SVH
`define JCP_IR_W 4
`define JCP_IR_BYPASS 4'hF
`define JCP_IR_IDCODE 4'h1
`define JCP_IR_SAMPLE 4'h2
`define JCP_IR_CONFIG_IO 4'h3
`define JCP_IR_PROGRAM 4'h4
`define JCP_IR_STARTUP 4'h5
`define JCP_IR_CAPTURE 4'h5
`define JCP_IR_RESET `JCP_IR_IDCODE
`define JCP_IDCODE_RESET 32'h1234_5001
`define JCP_INIT_CYCLES 299
`define JCP_INIT_LAST 9'h12A
`define JCP_MODE_AS 2'h1
`define JCP_MODE_FAS 2'h3
`define JCP_SYNC_W 7
`endif

// ### verilog/jcp_pkg.sv
// Types of the test-port configuration loader
package jcp_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jcp_tap_type;
    typedef struct packed {
        logic tms;
        logic tdi;
    } jcp_jtag_in_type;
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jcp_jtag_out_type;
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } jcp_cfg_byte_type;
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        jcp_tap_type st;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic byp;
        logic [31:0] id_sh;
        logic [7:0] pgm_sh;
        logic [2:0] bit_cnt;
        logic [7:0] byte_q;
        logic byte_tgl;
        logic cfg_act;
        logic loaded;
        logic io_mode;
        logic [8:0] init_cnt;
        logic init_done;
    } jcp_tck_type;
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jcp_neg_type;
    typedef struct packed {
        logic [6:0] s_m;
        logic [6:0] s_s;
        logic [6:0] s_t;
        logic [6:0] s_f;
        logic tgl_seen;
        logic act_old;
        jcp_cfg_byte_type cfg;
        logic ps_abort;
        logic hiz;
        logic sclk;
        logic sclk_oe;
        logic decomp;
        logic done;
    } jcp_clk_type;
endpackage

// ### verilog/jcp_config_port.sv
// Test-port configuration loader: TAP on the link clock, system side on clk_i
// What this block does
// - Test-port instructions override every other configuration mode immediately.
// - Starting test-port configuration aborts a passive serial load in progress.
// - In active serial modes the configuration serial clock is not driven meanwhile.
// - No decompression is applied to data loaded through the test port.
// - All user I/O stay high impedance during test-port configuration.
// - Instruction and data bits are taken from TDI on rising TCK.
// - TDO changes to the next bit on falling TCK while shifting.
// - TDO is high impedance whenever nothing is being shifted out.
// - TMS is sampled and the TAP advances only on rising TCK.
// - TCK low with TDI and TMS high leaves the port idle.
// - Bypass passes TDI to TDO through one register, one cycle late.
// - After the last bit, 299 more TCK cycles complete initialization.
// - During configuration only bypass, identification, sample, program, startup and I/O reconfiguration run; others become bypass.
module jcp_config_port (
    // System clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Test port, clocked by TCK
    input wire logic tck_i,
    input wire jcp_pkg::jcp_jtag_in_type jtag_i,
    output jcp_pkg::jcp_jtag_out_type jtag_o,
    // Other configuration engines and pins
    input wire logic [1:0] config_mode_select_i,
    input wire logic passive_serial_mode_i,
    input wire logic as_clk_i,
    input wire logic decompress_req_i,
    output logic config_serial_clock_o,
    output logic config_serial_clock_oe_o,
    output logic ps_abort_o,
    output logic decompress_en_o,
    // Configuration stream and status
    output jcp_pkg::jcp_cfg_byte_type cfg_o,
    output logic user_io_hiz_o,
    output logic config_done_o
);
    import jcp_pkg::*;
    `include "jcp_defines.svh"

    jcp_tck_type t;
    jcp_tck_type next_t;
    jcp_neg_type n;
    jcp_neg_type next_n;
    jcp_clk_type c;
    jcp_clk_type next_c;
    logic rst_t;
    logic as_mode;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    // Standard TAP transition
    function automatic jcp_tap_type tap_next(input jcp_tap_type s, input logic tms);
        unique case (s)
            TLR: tap_next = tms ? TLR : RTI;
            RTI: tap_next = tms ? SEL_DR : RTI;
            SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
            SH_DR: tap_next = tms ? EX1_DR : SH_DR;
            EX1_DR: tap_next = tms ? UPD_DR : PAU_DR;
            PAU_DR: tap_next = tms ? EX2_DR : PAU_DR;
            EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
            UPD_DR: tap_next = tms ? SEL_DR : RTI;
            SEL_IR: tap_next = tms ? TLR : CAP_IR;
            CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
            SH_IR: tap_next = tms ? EX1_IR : SH_IR;
            EX1_IR: tap_next = tms ? UPD_IR : PAU_IR;
            PAU_IR: tap_next = tms ? EX2_IR : PAU_IR;
            EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
            UPD_IR: tap_next = tms ? SEL_DR : RTI;
        endcase
    endfunction

    // Instructions that may run without disturbing a load
    function automatic logic cfg_safe(input logic [3:0] op);
        cfg_safe = (op == `JCP_IR_BYPASS) || (op == `JCP_IR_IDCODE) || (op == `JCP_IR_SAMPLE)
            || (op == `JCP_IR_PROGRAM) || (op == `JCP_IR_STARTUP) || (op == `JCP_IR_CONFIG_IO);
    endfunction

    // Accept a synchronised bit once second and third stage agree
    function automatic logic [6:0] agree(input logic [6:0] s2, input logic [6:0] s3, input logic [6:0] old);
        agree = (s2 & s3) | (old & (s2 | s3));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // TCK rising-edge logic
    assign rst_t = t.rst_s;

    // TAP, instruction and data registers
    always_comb begin
        next_t = t;
        next_t.rst_m = rst_i;
        next_t.rst_s = t.rst_m;
        next_t.st = tap_next(t.st, jtag_i.tms);
        unique case (t.st)
            TLR: begin
                next_t.ir = `JCP_IR_RESET;
            end
            CAP_IR: begin
                next_t.ir_sh = `JCP_IR_CAPTURE;
            end
            SH_IR: begin
                next_t.ir_sh = {jtag_i.tdi, t.ir_sh[3:1]};
            end
            UPD_IR: begin
                // Unsafe instructions during a load fall back to bypass
                if (t.cfg_act && !cfg_safe(t.ir_sh)) begin
                    next_t.ir = `JCP_IR_BYPASS;
                end else begin
                    next_t.ir = t.ir_sh;
                end
                if (t.ir_sh == `JCP_IR_PROGRAM) begin
                    next_t.cfg_act = 1'b1;
                    next_t.loaded = 1'b0;
                    next_t.init_done = 1'b0;
                    next_t.io_mode = 1'b0;
                    next_t.bit_cnt = 3'h0;
                end
                if (t.ir_sh == `JCP_IR_STARTUP && t.cfg_act) begin
                    next_t.loaded = 1'b1;
                    next_t.init_cnt = 9'h000;
                end
                if (t.ir_sh == `JCP_IR_CONFIG_IO) begin
                    next_t.cfg_act = 1'b0;
                    next_t.io_mode = 1'b1;
                end
            end
            CAP_DR: begin
                next_t.byp = 1'b0;
                next_t.id_sh = `JCP_IDCODE_RESET;
            end
            SH_DR: begin
                next_t.byp = jtag_i.tdi;
                next_t.id_sh = {jtag_i.tdi, t.id_sh[31:1]};
                if (t.ir == `JCP_IR_PROGRAM && t.cfg_act) begin
                    next_t.pgm_sh = {jtag_i.tdi, t.pgm_sh[7:1]};
                    next_t.bit_cnt = t.bit_cnt + 3'h1;
                    if (t.bit_cnt == 3'h7) begin
                        next_t.byte_q = {jtag_i.tdi, t.pgm_sh[7:1]};
                        next_t.byte_tgl = ~t.byte_tgl;
                    end
                end
            end
            RTI: begin
                // Initialization clocks after the last bit
                if (t.ir == `JCP_IR_STARTUP && t.loaded && !t.init_done) begin
                    next_t.init_cnt = t.init_cnt + 9'h001;
                    if (t.init_cnt == `JCP_INIT_LAST) begin
                        next_t.init_done = 1'b1;
                        next_t.cfg_act = 1'b0;
                    end
                end
            end
            default: begin
            end
        endcase
        if (rst_t) begin
            next_t = '0;
            next_t.rst_m = t.rst_m;
            next_t.rst_s = t.rst_s;
            next_t.st = TLR;
            next_t.ir = `JCP_IR_RESET;
        end
        next_t.rst_m = rst_i;
        next_t.rst_s = t.rst_m;
    end

    // Rising-edge state register
    always_ff @(posedge tck_i) begin
        t <= next_t;
    end

    ////////////////////////////////////////////////////////////////////////
    // TCK falling-edge output
    always_comb begin
        next_n = n;
        next_n.tdo_oe = (t.st == SH_DR) || (t.st == SH_IR);
        if (t.st == SH_IR) begin
            next_n.tdo = t.ir_sh[0];
        end else if (t.st == SH_DR) begin
            next_n.tdo = (t.ir == `JCP_IR_IDCODE) ? t.id_sh[0] : t.byp;
        end
        if (rst_t) begin
            next_n = '0;
        end
    end

    // Falling-edge register
    always_ff @(negedge tck_i) begin
        n <= next_n;
    end

    assign jtag_o.tdo = n.tdo;
    assign jtag_o.tdo_oe = n.tdo_oe;

    ////////////////////////////////////////////////////////////////////////
    // System clock side: synchronisers and outputs
    assign as_mode = (c.s_f[6:5] == `JCP_MODE_AS) || (c.s_f[6:5] == `JCP_MODE_FAS);

    always_comb begin
        next_c = c;
        next_c.s_m = {config_mode_select_i, passive_serial_mode_i, t.byte_tgl, t.io_mode, t.init_done, t.cfg_act};
        next_c.s_s = c.s_m;
        next_c.s_t = c.s_s;
        next_c.s_f = agree(c.s_s, c.s_t, c.s_f);
        next_c.act_old = c.s_f[0];
        next_c.tgl_seen = c.s_f[3];
        // Byte taken as the filtered toggle moves, a cycle ahead of valid, while byte_q still stands
        next_c.cfg.valid = c.s_f[3] ^ c.tgl_seen;
        if (next_c.s_f[3] ^ c.s_f[3]) begin
            next_c.cfg.data = t.byte_q;
        end
        next_c.ps_abort = c.s_f[0] && !c.act_old && c.s_f[4];
        next_c.hiz = c.s_f[0] || c.s_f[2];
        next_c.sclk = as_clk_i;
        next_c.sclk_oe = as_mode && !c.s_f[0];
        next_c.decomp = decompress_req_i && !c.s_f[0];
        next_c.done = c.s_f[1];
        if (rst_i) begin
            next_c = '0;
        end
    end

    // System-side register
    always_ff @(posedge clk_i) begin
        c <= next_c;
    end

    assign cfg_o = c.cfg;
    assign ps_abort_o = c.ps_abort;
    assign user_io_hiz_o = c.hiz;
    assign config_serial_clock_o = c.sclk;
    assign config_serial_clock_oe_o = c.sclk_oe;
    assign decompress_en_o = c.decomp;
    assign config_done_o = c.done;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    AST_TLR_FIVE: assert property (@(posedge tck_i) disable iff (rst_t)
        jtag_i.tms [*5] |=> t.st == TLR) else $error("TAP not in reset after five TMS high");
    AST_TDO_IDLE_HIZ: assert property (@(negedge tck_i) disable iff (rst_t)
        !(t.st == SH_DR || t.st == SH_IR) |=> !jtag_o.tdo_oe) else $error("TDO driven outside shift");
    AST_BYPASS_ONE: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == SH_DR && t.ir == `JCP_IR_BYPASS) ##1 (t.st == SH_DR) |-> jtag_o.tdo == $past(jtag_i.tdi))
        else $error("Bypass TDO not one cycle late");
    AST_PGM_CAPTURE: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == SH_DR && t.ir == `JCP_IR_PROGRAM && t.cfg_act) |=> t.pgm_sh[7] == $past(jtag_i.tdi))
        else $error("TDI bit not captured on rising edge");
    AST_INIT_COUNT: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == RTI && t.ir == `JCP_IR_STARTUP && t.loaded && !t.init_done && t.init_cnt == `JCP_INIT_LAST)
        |=> t.init_done && !t.cfg_act) else $error("Initialization not done after 299 cycles");
    AST_UNSAFE_IR: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == UPD_IR && t.cfg_act && !cfg_safe(t.ir_sh)) |=> t.ir == `JCP_IR_BYPASS)
        else $error("Unsafe instruction ran during load");
    AST_IO_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
        c.s_f[0] |=> user_io_hiz_o) else $error("User I/O driven during configuration");
    AST_NO_SCLK: assert property (@(posedge clk_i) disable iff (rst_i)
        (c.s_f[0] && as_mode) |=> !config_serial_clock_oe_o) else $error("Serial clock driven during load");
    AST_PS_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(c.s_f[0]) && c.s_f[4]) |=> ps_abort_o) else $error("Passive serial load not aborted");
    AST_NO_DECOMP: assert property (@(posedge clk_i) disable iff (rst_i)
        c.s_f[0] |=> !decompress_en_o) else $error("Decompression enabled during load");
    // Shift output, instruction and load control on the link clock
    AST_SHIFT_OE: assert property (@(negedge tck_i) disable iff (rst_t)
        (t.st == SH_DR || t.st == SH_IR) |=> jtag_o.tdo_oe) else $error("TDO not driven while shifting");
    AST_IR_TDO: assert property (@(negedge tck_i) disable iff (rst_t)
        (t.st == SH_IR) |=> jtag_o.tdo == $past(t.ir_sh[0])) else $error("Instruction bit not on TDO");
    AST_ID_TDO: assert property (@(negedge tck_i) disable iff (rst_t)
        (t.st == SH_DR && t.ir == `JCP_IR_IDCODE) |=> jtag_o.tdo == $past(t.id_sh[0]))
        else $error("Identification bit not on TDO");
    AST_TAP_STEP: assert property (@(posedge tck_i) disable iff (rst_t)
        1'b1 |=> t.st == tap_next($past(t.st), $past(jtag_i.tms)))
        else $error("TAP did not follow TMS on rising edge");
    AST_CAPTURE_IR: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == CAP_IR) |=> t.ir_sh == `JCP_IR_CAPTURE) else $error("Instruction capture value wrong");
    AST_TLR_IR: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == TLR) |=> t.ir == `JCP_IR_RESET) else $error("Instruction not reset in reset state");
    AST_PGM_START: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == UPD_IR && t.ir_sh == `JCP_IR_PROGRAM) |=> t.cfg_act && t.ir == `JCP_IR_PROGRAM)
        else $error("Load did not start at once");
    AST_IO_END: assert property (@(posedge tck_i) disable iff (rst_t)
        (t.st == UPD_IR && t.ir_sh == `JCP_IR_CONFIG_IO) |=> !t.cfg_act && t.io_mode)
        else $error("I/O reconfiguration did not end the load");
    // System-side levels and strobes
    AST_DONE_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
        c.s_f[1] |=> config_done_o) else $error("Done not shown after initialization");
    AST_SCLK_FREE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!c.s_f[0] && as_mode) |=> config_serial_clock_oe_o) else $error("Serial clock held off outside load");
    AST_DECOMP_FREE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!c.s_f[0] && decompress_req_i) |=> decompress_en_o) else $error("Decompression blocked outside load");
    AST_HIZ_IO_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
        c.s_f[2] |=> user_io_hiz_o) else $error("User I/O driven in I/O reconfiguration");
    AST_ABORT_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ps_abort_o |=> !ps_abort_o) else $error("Abort pulse longer than one cycle");
    AST_BYTE_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_o.valid |=> !cfg_o.valid) else $error("Byte strobe longer than one cycle");
    // Main scenarios reached
    COV_BYTE: cover property (@(posedge clk_i) disable iff (rst_i) cfg_o.valid);
    COV_DONE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(config_done_o));
    COV_ABORT: cover property (@(posedge clk_i) disable iff (rst_i) ps_abort_o);
    COV_BYPASS: cover property (@(posedge tck_i) disable iff (rst_t) t.st == SH_DR && t.ir == `JCP_IR_BYPASS);
    COV_IO_MODE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(c.s_f[2]));
endmodule

// ### test/jcp_jtag_host.sv
// Model of the external test-port controller driving TCK, TMS and TDI
module jcp_jtag_host (
    // Test port towards the device
    output logic tck_o,
    output jcp_pkg::jcp_jtag_in_type jtag_o,
    input wire jcp_pkg::jcp_jtag_out_type jtag_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import jcp_pkg::*;
    logic last_tdo;
    logic tdo_w;
    ////////////////////////////////////////////////////////////////////////////////
    // Released TDO shows the inverse of its last driven level
    assign tdo_w = (jtag_i.tdo_oe === 1'b1) ? jtag_i.tdo : ~last_tdo;
    always @(posedge tck_o) begin
        if (jtag_i.tdo_oe === 1'b1) last_tdo <= jtag_i.tdo;
    end
    // Idle pins: clock low, TMS and TDI high
    initial begin
        tck_o = 1'b0;
        jtag_o = 2'b11;
        last_tdo = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One TCK period; TMS and TDI settle while TCK is low, TDO is taken before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        jtag_o.tms = tms;
        jtag_o.tdi = tdi;
        #15;
        tdo = tdo_w;
        tck_o = 1'b1;
        #15;
        tck_o = 1'b0;
    endtask
    // Several periods at a fixed TMS, clock stops afterwards
    task automatic run(input int n, input logic tms);
        logic d;
        repeat (n) step(tms, 1'b1, d);
        jtag_o = 2'b11;
    endtask
    // Five TMS-high edges, then into Run-Test-Idle
    task automatic reset_tap();
        logic d;
        run(5, 1'b1);
        step(1'b0, 1'b1, d);
        jtag_o = 2'b11;
    endtask
    // Instruction load from Run-Test-Idle back to Run-Test-Idle
    task automatic shift_ir(input logic [3:0] code);
        logic d;
        step(1'b1, 1'b1, d);
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < 4; i++) step(i == 3, code[i], d);
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        jtag_o = 2'b11;
    endtask
    // Data scan of n bits, LSB first, returning what TDO carried
    task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic d;
        dout = 32'h0000_0000;
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        step(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b1, d);
        step(1'b0, 1'b1, d);
        jtag_o = 2'b11;
    endtask
endmodule

// ### test/tb_jcp_config_port.sv
// Self-checking bench of the test-port configuration loader
`include "jcp_defines.svh"
module tb_jcp_config_port;
    timeunit 1ns;
    timeprecision 100ps;
    import jcp_pkg::*;
    logic clk_i, rst_i, tck, ps_mode, as_clk, dreq, sclk, sclk_oe, ps_abort, dec_en, hiz, done;
    logic [1:0] config_mode_select;
    logic [31:0] d;
    jcp_jtag_in_type jin;
    jcp_jtag_out_type jout;
    jcp_cfg_byte_type cfg;
    int failures, compares, cycles, aborts;
    logic [7:0] bytes[$];
    logic [3:0] codes[2] = '{`JCP_IR_BYPASS, `JCP_IR_SAMPLE};
    ////////////////////////////////////////////////////////////////////////////////
    // Device and controller model
    jcp_config_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .jtag_i(jin), .jtag_o(jout),
        .config_mode_select_i(config_mode_select), .passive_serial_mode_i(ps_mode), .as_clk_i(as_clk),
        .decompress_req_i(dreq), .config_serial_clock_o(sclk), .config_serial_clock_oe_o(sclk_oe),
        .ps_abort_o(ps_abort), .decompress_en_o(dec_en), .cfg_o(cfg), .user_io_hiz_o(hiz),
        .config_done_o(done));
    jcp_jtag_host host_u (.tck_o(tck), .jtag_o(jin), .jtag_i(jout));
    // System clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Active serial engine clock
    always @(posedge clk_i) as_clk <= #2 ~as_clk;
    // Byte and abort monitor, run limit
    always @(posedge clk_i) begin
        if (cfg.valid === 1'b1) bytes.push_back(cfg.data);
        if (ps_abort === 1'b1) aborts++;
        cycles++;
        if (cycles == 6000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Tied-idle port stays quiet
    task automatic test_idle();
        wait_clk(20);
        chk(jout.tdo_oe, 1'b0);
        chk(bytes.size(), 0);
        chk(hiz, 1'b0);
        chk(done, 1'b0);
        chk(sclk_oe, 1'b1);
        #10;
        chk(sclk ^ as_clk, 1'b1);
        $display("test idle done");
    endtask
    // Identification scan straight after TAP reset
    task automatic test_idcode();
        host_u.reset_tap();
        host_u.shift_dr(32, 32'h0000_0000, d);
        chk(d, `JCP_IDCODE_RESET);
        chk(jout.tdo_oe, 1'b0);
        $display("test idcode done");
    endtask
    // One-bit path: output is input delayed one period, first bit captured zero
    task automatic test_bypass();
        foreach (codes[k]) begin
            host_u.shift_ir(codes[k]);
            host_u.shift_dr(8, 32'h0000_00A5, d);
            chk(d[7:0], 8'h4A);
        end
        $display("test bypass done");
    endtask
    // Load over a passive serial load in active serial mode
    task automatic test_load();
        wait_clk(1);
        config_mode_select = `JCP_MODE_FAS;
        chk(dec_en, 1'b1);
        host_u.shift_ir(`JCP_IR_PROGRAM);
        wait_clk(10);
        chk(aborts, 1);
        chk(hiz, 1'b1);
        chk(sclk_oe, 1'b0);
        chk(dec_en, 1'b0);
        host_u.shift_dr(16, 32'h0000_3CA5, d);
        wait_clk(10);
        chk(bytes.size(), 2);
        chk(bytes[0], 8'hA5);
        chk(bytes[1], 8'h3C);
        host_u.shift_ir(`JCP_IR_IDCODE);
        host_u.shift_dr(32, 32'h0000_0000, d);
        chk(d, `JCP_IDCODE_RESET);
        chk(hiz, 1'b1);
        host_u.shift_ir(4'h0);
        host_u.shift_dr(8, 32'h0000_00A5, d);
        chk(d[7:0], 8'h4A);
        chk(bytes.size(), 2);
        host_u.shift_ir(`JCP_IR_STARTUP);
        host_u.run(298, 1'b0);
        wait_clk(10);
        chk(done, 1'b0);
        host_u.run(1, 1'b0);
        wait_clk(10);
        chk(done, 1'b1);
        chk(aborts, 1);
        chk(hiz, 1'b0);
        chk(dec_en, 1'b1);
        host_u.shift_ir(`JCP_IR_CONFIG_IO);
        wait_clk(10);
        chk(hiz, 1'b1);
        chk(sclk_oe, 1'b1);
        $display("test load done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        config_mode_select = `JCP_MODE_AS;
        ps_mode = 1'b1;
        as_clk = 1'b0;
        dreq = 1'b1;
        failures = 0;
        compares = 0;
        cycles = 0;
        aborts = 0;
        host_u.run(6, 1'b1);
        repeat (20) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        chk(jout.tdo_oe, 1'b0);
        chk(aborts, 0);
        test_idle();
        test_idcode();
        test_bypass();
        test_load();
        end_of_test();
    end
endmodule
